/* rtl/simd_register_state.sv */
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "simd_state_defines.svh"
// Functional notes
// - eight 128-bit vector registers numbered 0 to 7 for float and integer data
// - scalar double operations use only the low 64-bit quadword
// - a 32-bit control/status register governs vector floating-point handling
// - denormals-are-zeros flag sits at bit 6 of control/status
// - eight 64-bit packed-integer registers, a file separate from the vector registers
// - memory addresses come only from general registers, never these files
// - some vector compares write their outcome into the flags register
// - vector file independent of packed-integer and legacy stack, concurrent use
// - save/restore moves vector, control/status and packed-integer state together
// - both generations share one state, no save needed between them
// - usable in protected, real-address and virtual-8086 modes alike
// - identification reports whether the extended feature is present
// - scalar ops copy upper quadword of first source into destination
module simd_register_state
  import simd_state_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution unit port, vector file
  input wire reg_sel_t ex_vec_rsel,
  output vec_word_t ex_vec_rdata,
  input wire logic ex_vec_we,
  input wire reg_sel_t ex_vec_wsel,
  input wire vec_word_t ex_vec_wdata,
  // execution unit port, packed-integer file (independent of the vector port)
  input wire reg_sel_t ex_pint_rsel,
  output quad_word_t ex_pint_rdata,
  input wire logic ex_pint_we,
  input wire reg_sel_t ex_pint_wsel,
  input wire quad_word_t ex_pint_wdata,
  // compare outcome toward processor_flags_reg
  input wire logic ex_cmp_we,
  input wire logic [31:0] ex_cmp_flags,
  output logic [31:0] processor_flags_reg,
  // control outputs
  output logic daz_en,
  output logic ftz_en,
  output logic busy
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`NUM_REGS-1:0][127:0] vec;
    logic [`NUM_REGS-1:0][63:0] pint;
    logic [31:0] csr;
    logic [31:0] flags;
    logic [3:0] cmd;
    logic [2:0] index;
    logic [3:0][31:0] data;
    exec_mode_t mode;
    xfer_state_t st;
    logic [4:0] slot;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // save area: slot 0 csr, slots 1..8 vector, 9..16 packed-integer
  logic [127:0] save_mem [0:`SAVE_SLOTS-1];
  logic save_we;
  logic [127:0] save_wdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
    hit = (a == base);
  endfunction

  // four staging words form one 128-bit value
  function automatic logic in_data(input logic [11:0] a);
    in_data = (a >= `ADDR_DATA0) && (a < `ADDR_DATA0 + `DATA_WINDOW);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = hit(a, `ADDR_CTRL_STATUS) || hit(a, `ADDR_CMD) || hit(a, `ADDR_INDEX) || in_data(a)
      || hit(a, `ADDR_FLAGS) || hit(a, `ADDR_FEATURE) || hit(a, `ADDR_MODE);
  endfunction

  // ------------------------------------------------------------
  // scalar path helpers
  // ------------------------------------------------------------
  quad_word_t low_raw;
  quad_word_t low_daz;
  vec_word_t merged;

  denormal_zero denormal_zero_i
  (
    .daz_en(s_reg.csr[`CSR_DAZ_BIT]),
    .in_val(low_raw),
    .out_val(low_daz)
  );

  scalar_merge scalar_merge_i
  (
    .first_src(s_reg.vec[s_reg.index]),
    .low_result(low_daz),
    .merged(merged)
  );

  // scalar merge takes only the low quadword of the staged data
  assign low_raw = {s_reg.data[1], s_reg.data[0]};

  wire logic access = psel && penable;
  wire logic wr = access && pwrite;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    save_we = 1'b0;
    save_wdata = 128'h0;
    // execution ports run concurrently on separate files
    if (ex_vec_we)
      s_next.vec[ex_vec_wsel] = ex_vec_wdata;
    if (ex_pint_we)
      s_next.pint[ex_pint_wsel] = ex_pint_wdata;
    if (ex_cmp_we)
      s_next.flags = (s_reg.flags & ~`FLAGS_CMP_MASK) | (ex_cmp_flags & `FLAGS_CMP_MASK);
    case (s_reg.st)
      st_idle:
      begin
        if (wr)
        begin
          if (hit(paddr, `ADDR_CTRL_STATUS))
            s_next.csr = pwdata & `CSR_WRITE_MASK;
          else if (hit(paddr, `ADDR_INDEX))
            s_next.index = pwdata[2:0];
          else if (in_data(paddr))
            s_next.data[paddr[3:2]] = pwdata;
          else if (hit(paddr, `ADDR_MODE) && pwdata[1:0] <= `MODE_MAX)
            s_next.mode = exec_mode_t'(pwdata[1:0]);
          else if (hit(paddr, `ADDR_CMD))
          begin
            s_next.cmd = pwdata[3:0];
            case (pwdata[3:0])
              `CMD_WR_VEC: s_next.vec[s_reg.index] = s_reg.data;
              `CMD_RD_VEC: s_next.data = s_reg.vec[s_reg.index];
              `CMD_WR_PINT: s_next.pint[s_reg.index] = {s_reg.data[1], s_reg.data[0]};
              `CMD_RD_PINT: s_next.data = {64'h0, s_reg.pint[s_reg.index]};
              `CMD_SCALAR_MERGE: s_next.vec[s_reg.index] = merged;
              `CMD_SAVE:
              begin
                s_next.st = st_save;
                s_next.slot = 5'h00;
              end
              `CMD_RESTORE:
              begin
                s_next.st = st_restore;
                s_next.slot = 5'h00;
              end
              default: s_next.cmd = s_reg.cmd;
            endcase
          end
        end
      end
      st_save:
      begin
        // one slot per cycle so the save array maps to a single-port memory
        save_we = 1'b1;
        if (s_reg.slot == `SLOT_CSR)
          save_wdata = {96'h0, s_reg.csr};
        else if (s_reg.slot <= `SLOT_VEC_LAST)
          save_wdata = s_reg.vec[3'(s_reg.slot - `SLOT_VEC_FIRST)];
        else
          save_wdata = {64'h0, s_reg.pint[3'(s_reg.slot - `SLOT_PINT_FIRST)]};
        s_next.slot = s_reg.slot + 5'h01;
        if (s_reg.slot == 5'(`SAVE_SLOTS - 1))
          s_next.st = st_idle;
      end
      st_restore:
      begin
        if (s_reg.slot == `SLOT_CSR)
          s_next.csr = save_mem[`SLOT_CSR][31:0] & `CSR_WRITE_MASK;
        else if (s_reg.slot <= `SLOT_VEC_LAST)
          s_next.vec[3'(s_reg.slot - `SLOT_VEC_FIRST)] = save_mem[s_reg.slot];
        else
          s_next.pint[3'(s_reg.slot - `SLOT_PINT_FIRST)] = save_mem[s_reg.slot][63:0];
        s_next.slot = s_reg.slot + 5'h01;
        if (s_reg.slot == 5'(`SAVE_SLOTS - 1))
          s_next.st = st_idle;
      end
      default: s_next.st = st_idle;
    endcase
    // read data is captured in the setup cycle and returned in the access cycle
    s_next.rdata = 32'h0;
    if (psel && !penable && !pwrite)
    begin
      if (hit(paddr, `ADDR_CTRL_STATUS))
        s_next.rdata = s_next.csr;
      else if (hit(paddr, `ADDR_CMD))
        s_next.rdata = {27'h0, s_reg.st != st_idle, s_reg.cmd};
      else if (hit(paddr, `ADDR_INDEX))
        s_next.rdata = {29'h0, s_reg.index};
      else if (in_data(paddr))
        s_next.rdata = s_reg.data[paddr[3:2]];
      else if (hit(paddr, `ADDR_FLAGS))
        s_next.rdata = s_reg.flags;
      else if (hit(paddr, `ADDR_FEATURE))
        s_next.rdata = `FEATURE_VALUE;
      else if (hit(paddr, `ADDR_MODE))
        s_next.rdata = {30'h0, s_reg.mode};
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
      s_reg.csr <= `CSR_RESET;
      s_reg.mode <= mode_real;
      s_reg.st <= st_idle;
    end
    else
      s_reg <= s_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (save_we)
      save_mem[s_reg.slot] <= save_wdata;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // no port here yields an address: memory addressing stays with general registers
  assign ex_vec_rdata = s_reg.vec[ex_vec_rsel];
  assign ex_pint_rdata = s_reg.pint[ex_pint_rsel];
  assign processor_flags_reg = s_reg.flags;
  assign daz_en = s_reg.csr[`CSR_DAZ_BIT];
  assign ftz_en = s_reg.csr[`CSR_FTZ_BIT];
  assign busy = s_reg.st != st_idle;
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;

  // unmapped addresses answer with an error
  always_comb
  begin
    pslverr = 1'b0;
    if (access && !is_mapped(paddr))
      pslverr = 1'b1;
  end

endmodule

/* rtl/simd_state_defines.svh */
`ifndef SIMD_STATE_DEFINES_SVH
`define SIMD_STATE_DEFINES_SVH

// register map (byte addresses on the bus)
`define ADDR_CTRL_STATUS 12'h000
`define ADDR_CMD 12'h004
`define ADDR_INDEX 12'h008
`define ADDR_DATA0 12'h010
`define ADDR_FLAGS 12'h030
`define ADDR_FEATURE 12'h034
`define ADDR_MODE 12'h038

// simd_control_status layout
`define CSR_DAZ_BIT 6
`define CSR_FTZ_BIT 15
`define CSR_RESET 32'h0000_1f80
`define CSR_WRITE_MASK 32'h0000_ffff

// feature word: bit 0 second generation present, bit 1 save/restore present
`define FEATURE_VALUE 32'h0000_0003

// command codes written to the command register
`define CMD_WR_VEC 4'h1
`define CMD_RD_VEC 4'h2
`define CMD_WR_PINT 4'h3
`define CMD_RD_PINT 4'h4
`define CMD_SCALAR_MERGE 4'h5
`define CMD_SAVE 4'h6
`define CMD_RESTORE 4'h7

`define NUM_REGS 8
`define SAVE_SLOTS 17
// save area slot boundaries
`define SLOT_CSR 5'h00
`define SLOT_VEC_FIRST 5'h01
`define SLOT_VEC_LAST 5'h08
`define SLOT_PINT_FIRST 5'h09
// size of the staging data window and highest legal mode code
`define DATA_WINDOW 12'h010
`define MODE_MAX 2'h2
`define FLAGS_CMP_MASK 32'h0000_08d5

`endif

/* rtl/simd_state_pkg.sv */
package simd_state_pkg;
  typedef logic [127:0] vec_word_t;
  typedef logic [63:0] quad_word_t;
  typedef logic [2:0] reg_sel_t;
  typedef enum logic [1:0] {mode_protected, mode_real, mode_v86} exec_mode_t;
  typedef enum {st_idle, st_save, st_restore} xfer_state_t;
endpackage

/* rtl/denormal_zero.sv */
`timescale 1ns/1ps
`include "simd_state_defines.svh"
module denormal_zero
  import simd_state_pkg::*;
(
  // control
  input wire logic daz_en,
  // operand
  input wire quad_word_t in_val,
  output quad_word_t out_val
);
  // exponent zero with a nonzero fraction is a denormal; keep only the sign
  always_comb
  begin
    if (daz_en && in_val[62:52] == 11'h000 && in_val[51:0] != 52'h0)
      out_val = {in_val[63], 63'h0};
    else
      out_val = in_val;
  end
endmodule

/* rtl/scalar_merge.sv */
`timescale 1ns/1ps
module scalar_merge
  import simd_state_pkg::*;
(
  // sources
  input wire vec_word_t first_src,
  input wire quad_word_t low_result,
  // destination
  output vec_word_t merged
);
  // scalar ops only write the low quadword; the upper half passes through
  assign merged = {first_src[127:64], low_result};
endmodule

/* test/simd_state_assertions.sv */
`timescale 1ns/1ps
`include "simd_state_defines.svh"
module simd_state_assertions
  import simd_state_pkg::*;
(
  // apb
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // execution ports
  input wire reg_sel_t ex_vec_rsel,
  input wire vec_word_t ex_vec_rdata,
  input wire logic ex_vec_we,
  input wire reg_sel_t ex_vec_wsel,
  input wire vec_word_t ex_vec_wdata,
  input wire reg_sel_t ex_pint_rsel,
  input wire quad_word_t ex_pint_rdata,
  input wire logic ex_pint_we,
  input wire reg_sel_t ex_pint_wsel,
  input wire quad_word_t ex_pint_wdata,
  input wire logic ex_cmp_we,
  input wire logic [31:0] ex_cmp_flags,
  input wire logic [31:0] processor_flags_reg,
  input wire logic daz_en,
  input wire logic busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire acc = psel && penable;
  wire apw = acc && pwrite;
  wire wr = apw && !busy;
  sequence busy_run;
    busy [*8] ##1 busy [*8] ##1 busy ##1 !busy;
  endsequence
  AST_PREADY: assert property (acc |-> pready)
    else $error("access without ready");
  AST_UNMAPPED: assert property (acc && paddr[11:6] != 0 |-> pslverr)
    else $error("unmapped access without slave error");
  AST_FEATURE: assert property (psel && !penable && !pwrite && paddr == `ADDR_FEATURE |=> prdata == `FEATURE_VALUE)
    else $error("feature word wrong");
  AST_DAZ: assert property (wr && paddr == `ADDR_CTRL_STATUS |=> daz_en == $past(pwdata[`CSR_DAZ_BIT]))
    else $error("daz flag does not follow bit 6");
  AST_FLAGS: assert property (ex_cmp_we |=> processor_flags_reg ==
    ($past(processor_flags_reg) & ~`FLAGS_CMP_MASK | $past(ex_cmp_flags) & `FLAGS_CMP_MASK))
    else $error("compare outcome not merged into flags");
  AST_VEC_WR: assert property (ex_vec_we && !apw && !busy ##1 ex_vec_rsel == $past(ex_vec_wsel)
    |-> ex_vec_rdata == $past(ex_vec_wdata)) else $error("vector write lost");
  AST_PINT_WR: assert property (ex_pint_we && !apw && !busy ##1 ex_pint_rsel == $past(ex_pint_wsel)
    |-> ex_pint_rdata == $past(ex_pint_wdata)) else $error("packed integer write lost");
  AST_XFER_BUSY: assert property (wr && paddr == `ADDR_CMD && pwdata[3:0] inside {`CMD_SAVE, `CMD_RESTORE}
    |=> busy_run) else $error("save or restore length wrong");
endmodule
bind simd_register_state simd_state_assertions chk_i (.*);

/* test/exec_unit_model.sv */
`timescale 1ns/1ps
module exec_unit_model
  import simd_state_pkg::*;
(
  // bench side
  input wire logic core_clk,
  input wire logic [2:0] go,
  input wire reg_sel_t sel,
  input wire vec_word_t val,
  // block side
  output logic ex_vec_we,
  output reg_sel_t ex_vec_wsel,
  output vec_word_t ex_vec_wdata,
  output logic ex_pint_we,
  output reg_sel_t ex_pint_wsel,
  output quad_word_t ex_pint_wdata,
  output logic ex_cmp_we,
  output logic [31:0] ex_cmp_flags
);
  logic [2:0] g = '0;
  reg_sel_t s = '0;
  vec_word_t d = '0;
  // one cycle of issue latency, like a unit writing back its result
  always @(posedge core_clk)
  begin
    g <= go;
    s <= sel;
    d <= val;
  end
  // idle data lines show the inverse so a stale value never looks valid
  assign ex_vec_we = g[0];
  assign ex_pint_we = g[1];
  assign ex_cmp_we = g[2];
  assign ex_vec_wsel = s;
  assign ex_pint_wsel = s;
  assign ex_vec_wdata = g[0] ? d : ~d;
  assign ex_pint_wdata = g[1] ? d[63:0] : ~d[63:0];
  assign ex_cmp_flags = g[2] ? d[31:0] : ~d[31:0];
endmodule

/* test/simd_register_state_test.sv */
`timescale 1ns/1ps
`include "simd_state_defines.svh"
module simd_register_state_test;
  import simd_state_pkg::*;
  logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, daz_en, ftz_en, busy;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, processor_flags_reg, ex_cmp_flags, r;
  logic [2:0] go = '0;
  reg_sel_t sel = '0, ex_vec_rsel = '0, ex_pint_rsel = '0, ex_vec_wsel, ex_pint_wsel;
  vec_word_t val = '0, ex_vec_rdata, ex_vec_wdata, vref [8];
  quad_word_t ex_pint_rdata, ex_pint_wdata;
  quad_word_t lo [2] = '{64'h8000_0000_0000_0001, 64'h3ff0_0000_0000_0000};
  logic ex_vec_we, ex_pint_we, ex_cmp_we;
  logic [32:0] exp_q [$];
  int fails = 0, n_checks = 0;
  simd_register_state simd_register_state_i (.*);
  exec_unit_model exec_unit_model_i (.*);
  initial forever #2 core_clk = ~core_clk;
  task automatic check(input string nm, input logic [128:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    // a read that never answered leaves its note behind
    fails += exp_q.size();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // --------------------------------
  // apb master and register helpers
  // --------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e = '0);
    int n = 0;
    if (!w)
      exp_q.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1 && n < 16);
    if (pready !== 1)
    begin
      fails++;
      summarize();
    end
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  always @(posedge core_clk)
    if (psel && penable && !pwrite && pready === 1)
      check("read", exp_q.size() ? exp_q.pop_front() : 'x, {pslverr, prdata});
  task automatic cmd(input int i, input logic [3:0] c);
    apb(1, `ADDR_INDEX, 32'(i));
    apb(1, `ADDR_CMD, {28'h0, c});
  endtask
  task automatic wvec(input int i, input vec_word_t x);
    for (int k = 0; k < 4; k++)
      apb(1, 12'(`ADDR_DATA0 + 4 * k), x[32 * k +: 32]);
    cmd(i, `CMD_WR_VEC);
  endtask
  task automatic rvec(input int i, input logic [3:0] c, input vec_word_t x);
    cmd(i, c);
    for (int k = 0; k < 4; k++)
      apb(0, 12'(`ADDR_DATA0 + 4 * k), 0, {1'b0, x[32 * k +: 32]});
  endtask
  task automatic idle;
    int n = 0;
    while (busy !== 0 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    if (busy !== 0)
    begin
      fails++;
      summarize();
    end
  endtask
  initial
  begin
    r = $urandom(66176);
    repeat (10) @(posedge core_clk);
    reset_n <= 1;
    apb(0, `ADDR_CTRL_STATUS, 0, {1'b0, `CSR_RESET});
    apb(0, `ADDR_FEATURE, 0, 33'h3);
    apb(0, 12'h040, 0, {1'b1, 32'h0});
    r = $urandom() | 32'h40;
    apb(1, `ADDR_CTRL_STATUS, r);
    apb(0, `ADDR_CTRL_STATUS, 0, {1'b0, r & `CSR_WRITE_MASK});
    check("daz", 1, daz_en);
    check("ftz", r[15], ftz_en);
    apb(0, `ADDR_MODE, 0, 33'h1);
    for (int m = 0; m < 4; m++)
    begin
      apb(1, `ADDR_MODE, m);
      apb(0, `ADDR_MODE, 0, m == 3 ? 33'h2 : 33'(m));
    end
    for (int i = 0; i < 8; i++)
    begin
      vref[i] = {$urandom, $urandom, $urandom, $urandom};
      wvec(i, vref[i]);
      ex_vec_rsel <= 3'(i);
      @(posedge core_clk);
      check("vec port", vref[i], ex_vec_rdata);
    end
    for (int i = 0; i < 8; i++)
      rvec(i, `CMD_RD_VEC, vref[i]);
    for (int j = 0; j < 2; j++)
    begin
      apb(1, `ADDR_DATA0, lo[j][31:0]);
      apb(1, `ADDR_DATA0 + 12'h4, lo[j][63:32]);
      cmd(2, `CMD_SCALAR_MERGE);
      vref[2][63:0] = j ? lo[j] : 64'h8000_0000_0000_0000;
      rvec(2, `CMD_RD_VEC, vref[2]);
    end
    val <= {$urandom, $urandom, $urandom, $urandom};
    sel <= 3'h5;
    ex_vec_rsel <= 3'h5;
    ex_pint_rsel <= 3'h5;
    go <= 3'h3;
    @(posedge core_clk);
    go <= 3'h0;
    repeat (3) @(posedge core_clk);
    check("pint port", val[63:0], ex_pint_rdata);
    check("vec port", val, ex_vec_rdata);
    vref[5] = val;
    rvec(5, `CMD_RD_VEC, val);
    rvec(5, `CMD_RD_PINT, {64'h0, val[63:0]});
    val <= '1;
    go <= 3'h4;
    @(posedge core_clk);
    go <= 3'h0;
    repeat (3) @(posedge core_clk);
    apb(0, `ADDR_FLAGS, 0, {1'b0, `FLAGS_CMP_MASK});
    check("flags port", `FLAGS_CMP_MASK, processor_flags_reg);
    cmd(0, `CMD_SAVE);
    apb(0, `ADDR_CMD, 0, {1'b0, 27'h0, 1'b1, `CMD_SAVE});
    apb(1, `ADDR_CTRL_STATUS, 32'h0);
    idle();
    apb(0, `ADDR_CTRL_STATUS, 0, {1'b0, r & `CSR_WRITE_MASK});
    wvec(0, ~vref[0]);
    cmd(5, `CMD_WR_PINT);
    check("pint port", {64'h0, ~vref[0][63:0]}, ex_pint_rdata);
    apb(1, `ADDR_CMD, 32'hf);
    apb(0, `ADDR_CMD, 0, {1'b0, 28'h0, `CMD_WR_PINT});
    apb(1, `ADDR_CTRL_STATUS, 32'h0);
    cmd(0, `CMD_RESTORE);
    idle();
    rvec(0, `CMD_RD_VEC, vref[0]);
    rvec(5, `CMD_RD_PINT, {64'h0, vref[5][63:0]});
    apb(0, `ADDR_CTRL_STATUS, 0, {1'b0, r & `CSR_WRITE_MASK});
    check("daz", 1, daz_en);
    summarize();
  end
endmodule
